// >>> sim/lcm_sub_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// subscriber transceiver: one 256-bit frame of 32 slots, msb first
module lcm_sub_model (
	input  wire logic         lk_clk_i,
	input  wire logic         sub_oe_i,
	input  wire logic [7:0]   up_ci_i,
	output logic              fsc_o,
	output logic              us_bit_o,
	output logic [255:0]      ds_frame_o
);
	logic [7:0]       bit_q = 8'hFF;
	logic [255:0]     shift_q = '1;
	logic [7:0]       ci_q = 8'hFF;
	wire  logic [7:0] nxt_w = bit_q + 8'h01;
	// open drain: a released line reads high through the pull-up
	wire  logic       line_w = ~sub_oe_i;
	// control pair sits in slots 2 and 3, every other slot idles high
	wire  logic [7:0] byte_w = (nxt_w[7:4] == 4'h1) ? ci_q : 8'hFF;

	initial begin
		fsc_o = 1'b0;
		us_bit_o = 1'b1;
		ds_frame_o = '1;
	end

	////////////////////////////////////////////////////////////////
	always @(negedge lk_clk_i) begin
		bit_q <= nxt_w;
		fsc_o <= (nxt_w == 8'hFF);
		us_bit_o <= byte_w[3'h7 - nxt_w[2:0]];
		// indication only changes at a frame boundary, never mid-byte
		if (nxt_w == 8'h00) begin
			ci_q <= up_ci_i;
		end
		shift_q <= {shift_q[254:0], line_w};
		if (bit_q == 8'hFF) begin
			ds_frame_o <= {shift_q[254:0], line_w};
		end
	end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module tb;
	import lcm_pkg::*;
	logic         mclk_i = 1'b0;
	logic         lk_clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         mode_wr_i = 1'b0, cmd_wr_i = 1'b0, ctl_wr_i = 1'b0, cif_rd_i = 1'b0;
	logic         main_status_rd_i = 1'b0, hdlc_status_rd_i = 1'b0, rx_valid_i = 1'b0, rx_end_i = 1'b0;
	logic         tx_wr_i = 1'b0, tx_ready_i = 1'b0;
	lcm_byte_t    mode_i = 8'h00, mem_cmd_i = 8'h00, mem_addr_i = 8'h00, mem_data_i = 8'h00;
	lcm_byte_t    ctl_cmd_i = 8'h00, arb_en_i = 8'h00, rx_status_i = 8'h00, tx_data_i = 8'h00;
	lcm_byte_t    up_ci = 8'hFF;
	logic         fsc_i, us_bit_i, busy_o, tx_valid_o, tx_end_o, sub_do_o, sub_oe_o;
	logic [3:0]   trunk_oe_o;
	lcm_byte_t    mem_rdata_o, main_status_o, cif_data_o, hdlc_status_o, rx_count_o, rx_status_o, tx_byte_o;
	logic [255:0] ds_frame;
	int           n_fail = 0;
	int           tests_run = 0;

	always #12.5 mclk_i = ~mclk_i;
	// link clock free-running, phase unrelated to mclk
	initial begin
		#7;
		forever #16 lk_clk_i = ~lk_clk_i;
	end

	lcm_ctrl #(.CIF_DEPTH(8), .TX_DEPTH(32)) lcm_ctrl_inst (.mclk_i, .rst_i, .mode_wr_i, .mode_i, .cmd_wr_i,
		.mem_cmd_i, .mem_addr_i, .mem_data_i, .ctl_wr_i, .ctl_cmd_i, .arb_en_i, .cif_rd_i, .main_status_rd_i,
		.hdlc_status_rd_i, .rx_valid_i, .rx_end_i, .rx_status_i, .tx_wr_i, .tx_data_i, .tx_ready_i, .lk_clk_i,
		.fsc_i, .us_bit_i, .busy_o, .mem_rdata_o, .main_status_o, .cif_data_o, .hdlc_status_o, .rx_count_o,
		.rx_status_o, .tx_valid_o, .tx_byte_o, .tx_end_o, .sub_do_o, .sub_oe_o, .trunk_oe_o);

	lcm_sub_model lcm_sub_model_inst (.lk_clk_i, .sub_oe_i(sub_oe_o), .up_ci_i(up_ci), .fsc_o(fsc_i),
		.us_bit_o(us_bit_i), .ds_frame_o(ds_frame));

	////////////////////////////////////////////////////////////////
	// all drives land 1 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic chk(input string nm, input lcm_byte_t exp, input lcm_byte_t got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// a free cycle after each strobe keeps two calls from meeting in one step
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask

	task automatic mem(input lcm_byte_t c, input lcm_byte_t a, input lcm_byte_t d);
		int w;
		w = 0;
		while (busy_o !== 1'b0 && w < 400) begin
			cyc(1);
			w++;
		end
		mem_cmd_i = c;
		mem_addr_i = a;
		mem_data_i = d;
		pulse(cmd_wr_i);
	endtask

	task automatic rd(input lcm_byte_t a, input lcm_byte_t exp);
		mem(LCM_CMD_RD_DATA, a, 8'h00);
		cyc(1);
		chk("mem_rdata", exp, mem_rdata_o);
	endtask

	task automatic wr_mode(input lcm_byte_t v);
		mode_i = v;
		pulse(mode_wr_i);
	endtask

	task automatic wr_ctl(input lcm_byte_t v);
		ctl_cmd_i = v;
		pulse(ctl_wr_i);
	endtask

	task automatic wait_st(input logic hd, input lcm_byte_t m, input lcm_byte_t e);
		lcm_byte_t v;
		int        w;
		w = 0;
		v = hd ? hdlc_status_o : main_status_o;
		while ((v & m) !== e && w < 1500) begin
			cyc(1);
			w++;
			v = hd ? hdlc_status_o : main_status_o;
		end
		chk(hd ? "hdlc_status" : "main_status", e, v & m);
	endtask

	// even slots of a pair carry monitor data, so only the odd slot is judged
	function automatic lcm_byte_t ds_slot(input int s);
		return ds_frame[255 - 8 * s -: 8];
	endfunction

	task automatic end_of_test;
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// whole run needs roughly 5k cycles
	initial begin
		#2_000_000;
		n_fail++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		int w;
		cyc(10);
		rst_i = 1'b0;
		chk("main_status", 8'h00, main_status_o);
		chk("busy", 8'h00, {7'h0, busy_o});
		mem(LCM_CMD_CLR, 8'h00, LCM_IDLE);
		cyc(1);
		chk("busy", 8'h01, {7'h0, busy_o});
		mem(LCM_CMD_WR_DATA, 8'h08, 8'h00);
		rd(8'h08, 8'hFF);
		wr_mode(LCM_MODE_INIT);
		mem(8'h7A, 8'h08, 8'hC3);
		mem(8'h7B, 8'h09, 8'hC3);
		mem(8'h78, 8'h88, 8'hFF);
		mem(8'h70, 8'h89, 8'hFF);
		mem(8'h7A, 8'h18, 8'hF3);
		mem(8'h7B, 8'h19, 8'hF3);
		cyc(1);
		chk("busy", 8'h00, {7'h0, busy_o});
		rd(8'h08, 8'hC3);
		mem(LCM_CMD_WR_DATA, 8'h08, 8'hF3);
		rd(8'h08, 8'hF3);
		wr_mode(LCM_MODE_NORM);
		chk("sub_do", 8'h00, {7'h0, sub_do_o});
		wait_st(1'b0, 8'h48, 8'h48);
		chk("main_status", 8'h48, main_status_o);
		wr_ctl(LCM_CMD_CIF_CLR);
		wait_st(1'b0, LCM_ST_CIC, 8'h00);
		pulse(main_status_rd_i);
		wait_st(1'b0, LCM_ST_SYNC, 8'h00);
		cyc(700);
		chk("ds_ctl0", 8'hF3, ds_slot(3));
		arb_en_i = 8'h01;
		cyc(700);
		chk("ds_ctl0", 8'hE3, ds_slot(3));
		chk("ds_ctl1", 8'hF3, ds_slot(7));
		chk("trunk_oe", 8'h00, {4'h0, trunk_oe_o});
		mem(LCM_CMD_TRI_ALL, 8'h00, 8'hF5);
		wr_mode(LCM_MODE_TRUNK);
		cyc(700);
		chk("trunk_oe", 8'h0A, {4'h0, trunk_oe_o});
		// three indication changes queue up unread
		for (int i = 0; i < 3; i++) begin
			up_ci = (i == 1) ? 8'hC3 : 8'hF3;
			cyc(700);
		end
		chk("main_status", LCM_ST_CIC, main_status_o & LCM_ST_CIC);
		for (int i = 0; i < 3; i++) begin
			pulse(cif_rd_i);
			cyc(1);
			chk("cif_data", 8'h88, cif_data_o);
		end
		wait_st(1'b0, LCM_ST_CIC, 8'h00);
		rd(8'h88, 8'hF3);
		rx_valid_i = 1'b1;
		cyc(8);
		rx_valid_i = 1'b0;
		rx_status_i = 8'h80;
		pulse(rx_end_i);
		cyc(1);
		chk("rx_count", 8'h09, rx_count_o);
		chk("rx_status", 8'h80, rx_status_o);
		wait_st(1'b1, LCM_HS_RME, LCM_HS_RME);
		wait_st(1'b0, LCM_ST_HDLC, LCM_ST_HDLC);
		wr_ctl(LCM_CMD_RX_ACK);
		cyc(1);
		chk("rx_count", 8'h00, rx_count_o);
		pulse(hdlc_status_rd_i);
		tx_wr_i = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tx_data_i = 8'hA0 + 8'(i);
			cyc(1);
		end
		tx_wr_i = 1'b0;
		wr_ctl(LCM_CMD_XMIT);
		// odd bytes see the serializer stall two cycles
		for (int i = 0; i < 8; i++) begin
			w = 0;
			while (tx_valid_o !== 1'b1 && w < 50) begin
				cyc(1);
				w++;
			end
			if (i % 2 == 1) cyc(2);
			chk("tx_byte", 8'hA0 + 8'(i), tx_byte_o);
			chk("tx_end", {7'h0, i == 7}, {7'h0, tx_end_o});
			chk("tx_valid", 8'h01, {7'h0, tx_valid_o});
			pulse(tx_ready_i);
		end
		wait_st(1'b1, LCM_HS_XPR, LCM_HS_XPR);
		chk("tx_valid", 8'h00, {7'h0, tx_valid_o});
		end_of_test();
	end
endmodule

// >>> src/lcm_ctrl.sv
`timescale 1ns/1ps
module lcm_ctrl #(
	parameter int CIF_DEPTH = lcm_pkg::LCM_CIF_DEPTH,
	parameter int TX_DEPTH  = lcm_pkg::LCM_TX_DEPTH
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              mode_wr_i,
	input  wire lcm_pkg::lcm_byte_t mode_i,
	input  wire logic              cmd_wr_i,
	input  wire lcm_pkg::lcm_byte_t mem_cmd_i,
	input  wire lcm_pkg::lcm_byte_t mem_addr_i,
	input  wire lcm_pkg::lcm_byte_t mem_data_i,
	input  wire logic              ctl_wr_i,
	input  wire lcm_pkg::lcm_byte_t ctl_cmd_i,
	input  wire lcm_pkg::lcm_byte_t arb_en_i,
	input  wire logic              cif_rd_i,
	input  wire logic              main_status_rd_i,
	input  wire logic              hdlc_status_rd_i,
	input  wire logic              rx_valid_i,
	input  wire logic              rx_end_i,
	input  wire lcm_pkg::lcm_byte_t rx_status_i,
	input  wire logic              tx_wr_i,
	input  wire lcm_pkg::lcm_byte_t tx_data_i,
	input  wire logic              tx_ready_i,
	input  wire logic              lk_clk_i,
	input  wire logic              fsc_i,
	input  wire logic              us_bit_i,
	output logic                   busy_o,
	output lcm_pkg::lcm_byte_t     mem_rdata_o,
	output lcm_pkg::lcm_byte_t     main_status_o,
	output lcm_pkg::lcm_byte_t     cif_data_o,
	output lcm_pkg::lcm_byte_t     hdlc_status_o,
	output lcm_pkg::lcm_byte_t     rx_count_o,
	output lcm_pkg::lcm_byte_t     rx_status_o,
	output logic                   tx_valid_o,
	output lcm_pkg::lcm_byte_t     tx_byte_o,
	output logic                   tx_end_o,
	output logic                   sub_do_o,
	output logic                   sub_oe_o,
	output logic [3:0]             trunk_oe_o
);
	import lcm_pkg::*;
	localparam int CAW = $clog2(CIF_DEPTH);
	localparam int TAW = $clog2(TX_DEPTH);

	lcm_byte_t data_mem [256];
	lcm_code_t code_mem [256];
	lcm_byte_t cif_mem  [CIF_DEPTH];
	lcm_byte_t tx_mem   [TX_DEPTH];

	lcm_byte_t mode_q, clr_data_q, clr_cnt_q, ds_byte_q, rx_cnt_q;
	logic      busy_q, sub_en_q, sync_q, ds_tog_q;
	lcm_slot_t ds_slot_q;
	logic [3:0] tri_q;
	logic [2:0] m_ut_q;
	logic [CAW:0] wr_q, rd_q;
	lcm_byte_t hs_q;
	lcm_tx_t   tx_st_q;
	logic [TAW:0] tx_n_q, tx_idx_q;

	// link side registers
	logic [1:0] lk_rst_q;
	logic [7:0] lk_bit_q, lk_ush_q, lk_ub_q, lk_dsh_q, lk_dhold_q;
	lcm_slot_t lk_uslot_q, lk_dslot_q;
	logic       lk_utog_q;
	logic [2:0] lk_dt_q;
	logic [5:0] lk_lv1_q, lk_lv2_q;

	//////////////////////////////////////////////////////////////////////
	// host memory access decode
	wire       host_go  = cmd_wr_i & ~busy_q;
	wire       is_wr7   = mem_cmd_i[7:4] == LCM_CMD_WR_NIB;
	wire       in_reset = mode_q == LCM_MODE_RESET;
	wire       clr_go   = host_go & in_reset & (mem_cmd_i == LCM_CMD_CLR);
	wire       wr_go    = host_go & ~in_reset & (is_wr7 | (mem_cmd_i == LCM_CMD_WR_DATA));
	wire       rd_go    = host_go & (mem_cmd_i == LCM_CMD_RD_DATA);
	wire       tri_go   = host_go & (mem_cmd_i == LCM_CMD_TRI_ALL);
	wire       sub_en   = (mode_q == LCM_MODE_NORM) | (mode_q == LCM_MODE_TRUNK);
	wire       trunk_en = mode_q == LCM_MODE_TRUNK;
	wire       start    = sub_en & ~sub_en_q;
	wire lcm_byte_t host_rd = data_mem[mem_addr_i];

	//////////////////////////////////////////////////////////////////////
	// upstream slot event and downstream preparation
	wire       ev       = m_ut_q[1] ^ m_ut_q[2];
	wire lcm_slot_t ev_slot = lk_uslot_q;
	wire lcm_byte_t ev_byte = lk_ub_q;
	wire lcm_byte_t a_ue    = lcm_slot_addr(LCM_DIR_UP, {ev_slot[4:1], 1'b0});
	wire       ci_diff  = ev_byte[LCM_CI_MSB:LCM_CI_LSB] != data_mem[a_ue][LCM_CI_MSB:LCM_CI_LSB];
	// host write wins the port; a change lost here is seen again next frame
	wire       ci_we    = ev & sub_en & ~busy_q & ~wr_go & ev_slot[0]
	                    & (code_mem[a_ue] == LCM_CODE_US_EVEN) & ci_diff;
	wire lcm_slot_t t_slot = lcm_slot_t'(ev_slot + LCM_SLOT_LEAD);
	wire lcm_byte_t a_de   = lcm_slot_addr(LCM_DIR_DOWN, {t_slot[4:1], 1'b0});
	wire lcm_byte_t a_dt   = lcm_slot_addr(LCM_DIR_DOWN, t_slot);
	wire       ds_ci    = t_slot[0] & (code_mem[a_dt] == LCM_CODE_DS_ODD)
	                    & (code_mem[a_de] == LCM_CODE_DS_EVEN);
	wire       arb_on   = arb_en_i[t_slot[4:2]];
	wire lcm_byte_t arb_mask = ~(lcm_byte_t'(1) << LCM_ARB_BIT);
	wire lcm_byte_t ds_ci_b  = arb_on ? (data_mem[a_de] & arb_mask) : data_mem[a_de];
	wire lcm_byte_t ds_next  = !sub_en ? LCM_IDLE :
	                           ds_ci ? ds_ci_b :
	                           (code_mem[a_dt] == LCM_CODE_UNASSIGNED) ? LCM_IDLE : data_mem[a_dt];

	//////////////////////////////////////////////////////////////////////
	// shared write port of the control memory
	wire lcm_byte_t w_addr = busy_q ? clr_cnt_q : (wr_go ? mem_addr_i : a_ue);
	wire lcm_byte_t w_data = busy_q ? clr_data_q : (wr_go ? mem_data_i : ev_byte);
	wire lcm_code_t w_code = busy_q ? LCM_CODE_UNASSIGNED : mem_cmd_i[3:0];
	wire       d_we     = busy_q | wr_go | ci_we;
	wire       c_we     = busy_q | (wr_go & is_wr7);

	always_ff @(posedge mclk_i) begin
		if (d_we) begin
			data_mem[w_addr] <= w_data;
		end
		if (c_we) begin
			code_mem[w_addr] <= w_code;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mode_q <= LCM_MODE_RESET;
			sub_en_q <= 1'b0;
		end else begin
			if (mode_wr_i) begin
				mode_q <= mode_i;
			end
			sub_en_q <= sub_en;
		end
	end

	// reset mode fill walks all 256 locations, one per cycle
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			clr_cnt_q <= '0;
			clr_data_q <= LCM_IDLE;
		end else if (clr_go) begin
			busy_q <= 1'b1;
			clr_cnt_q <= '0;
			clr_data_q <= mem_data_i;
		end else if (busy_q) begin
			busy_q <= clr_cnt_q != LCM_CLR_LAST;
			clr_cnt_q <= clr_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mem_rdata_o <= '0;
			tri_q <= '1;
		end else begin
			if (rd_go) begin
				mem_rdata_o <= host_rd;
			end
			if (tri_go) begin
				tri_q <= mem_data_i[3:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// command/indication change fifo
	wire       cif_clr  = ctl_wr_i & (ctl_cmd_i == LCM_CMD_CIF_CLR);
	wire [CAW:0] cif_cnt = wr_q - rd_q;
	wire       cif_full = cif_cnt == (CAW+1)'(CIF_DEPTH);
	wire       cif_ne   = cif_cnt != '0;
	// a push in the clearing cycle survives the clear
	wire       push     = (ci_we | start) & (~cif_full | cif_clr);
	wire lcm_byte_t pdata = start ? LCM_CIF_SPUR : a_ue;
	wire       pop      = cif_rd_i & cif_ne & ~cif_clr;

	always_ff @(posedge mclk_i) begin
		if (push) begin
			cif_mem[wr_q[CAW-1:0]] <= pdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cif_data_o <= '0;
		end else begin
			wr_q <= wr_q + (CAW+1)'(push);
			rd_q <= cif_clr ? wr_q : rd_q + (CAW+1)'(pop);
			if (pop) begin
				cif_data_o <= cif_mem[rd_q[CAW-1:0]];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// status registers; set wins over a read-clear in the same cycle
	wire       rx_done  = rx_end_i;
	wire       tx_fin   = (tx_st_q == LCM_TX_SEND) & (tx_idx_q == tx_n_q) & (~tx_valid_o | tx_ready_i);
	wire lcm_byte_t hs_set = (rx_done ? LCM_HS_RME : '0) | (tx_fin ? LCM_HS_XPR : '0);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sync_q <= 1'b0;
			hs_q <= '0;
			main_status_o <= '0;
			hdlc_status_o <= '0;
		end else begin
			sync_q <= start | (sync_q & ~main_status_rd_i);
			hs_q <= hs_set | (hs_q & ~{8{hdlc_status_rd_i}});
			main_status_o <= (cif_ne ? LCM_ST_CIC : '0) | (sync_q ? LCM_ST_SYNC : '0)
			               | ((|hs_q) ? LCM_ST_HDLC : '0);
			hdlc_status_o <= hs_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// subscriber hdlc receive count and transmit handshake
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rx_cnt_q <= '0;
			rx_count_o <= '0;
			rx_status_o <= '0;
		end else if (rx_done) begin
			rx_cnt_q <= '0;
			rx_count_o <= rx_cnt_q + lcm_byte_t'(rx_valid_i) + 8'h01;
			rx_status_o <= rx_status_i;
		end else begin
			rx_cnt_q <= rx_cnt_q + lcm_byte_t'(rx_valid_i);
			if (ctl_wr_i && ctl_cmd_i == LCM_CMD_RX_ACK) begin
				rx_count_o <= '0;
			end
		end
	end

	wire xmit_go = ctl_wr_i & (ctl_cmd_i == LCM_CMD_XMIT) & (tx_st_q == LCM_TX_IDLE) & (tx_n_q != '0);
	wire tx_adv  = (tx_st_q == LCM_TX_SEND) & (tx_idx_q != tx_n_q) & (~tx_valid_o | tx_ready_i);

	always_ff @(posedge mclk_i) begin
		if (tx_wr_i && tx_st_q == LCM_TX_IDLE && tx_n_q != (TAW+1)'(TX_DEPTH)) begin
			tx_mem[tx_n_q[TAW-1:0]] <= tx_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tx_st_q <= LCM_TX_IDLE;
			tx_n_q <= '0;
			tx_idx_q <= '0;
			tx_valid_o <= 1'b0;
			tx_byte_o <= '0;
			tx_end_o <= 1'b0;
		end else begin
			unique case (tx_st_q)
				LCM_TX_IDLE: begin
					if (xmit_go) begin
						tx_st_q <= LCM_TX_SEND;
						tx_idx_q <= '0;
					end else if (tx_wr_i && tx_n_q != (TAW+1)'(TX_DEPTH)) begin
						tx_n_q <= tx_n_q + 1'b1;
					end
				end
				LCM_TX_SEND: begin
					if (tx_adv) begin
						tx_valid_o <= 1'b1;
						tx_byte_o <= tx_mem[tx_idx_q[TAW-1:0]];
						tx_end_o <= tx_idx_q == tx_n_q - 1'b1;
						tx_idx_q <= tx_idx_q + 1'b1;
					end else if (tx_fin) begin
						tx_valid_o <= 1'b0;
						tx_end_o <= 1'b0;
						tx_n_q <= '0;
						tx_st_q <= LCM_TX_IDLE;
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// crossings to and from the link clock
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			m_ut_q <= '0;
			ds_tog_q <= 1'b0;
			ds_byte_q <= LCM_IDLE;
			ds_slot_q <= '0;
		end else begin
			m_ut_q <= {m_ut_q[1:0], lk_utog_q};
			if (ev) begin
				ds_byte_q <= ds_next;
				ds_slot_q <= t_slot;
				ds_tog_q <= ~ds_tog_q;
			end
		end
	end

	assign busy_o = busy_q;

	//////////////////////////////////////////////////////////////////////
	// link domain: serial slots, 8 link clocks per slot
	wire [5:0] lk_lv   = {sub_en, trunk_en, tri_q};
	wire       lk_rst  = lk_rst_q[1];
	wire       lk_last = lk_bit_q[2:0] == LCM_LAST_BIT;
	wire lcm_slot_t lk_slot = lk_bit_q[7:3];
	wire       lk_dnew = lk_dt_q[1] ^ lk_dt_q[2];

	always_ff @(posedge lk_clk_i) begin
		lk_rst_q <= {lk_rst_q[0], rst_i};
		lk_lv1_q <= lk_lv;
		lk_lv2_q <= lk_lv1_q;
	end

	always_ff @(posedge lk_clk_i) begin
		if (lk_rst) begin
			lk_bit_q <= '0;
			lk_ush_q <= '0;
			lk_ub_q <= LCM_IDLE;
			lk_uslot_q <= '0;
			lk_utog_q <= 1'b0;
		end else begin
			lk_bit_q <= fsc_i ? '0 : lk_bit_q + 8'h01;
			lk_ush_q <= {lk_ush_q[6:0], us_bit_i};
			if (lk_last) begin
				lk_ub_q <= {lk_ush_q[6:0], us_bit_i};
				lk_uslot_q <= lk_slot;
				lk_utog_q <= ~lk_utog_q;
			end
		end
	end

	// a byte that missed its slot is replaced by idle ones
	always_ff @(posedge lk_clk_i) begin
		if (lk_rst) begin
			lk_dt_q <= '0;
			lk_dhold_q <= LCM_IDLE;
			lk_dslot_q <= '0;
			lk_dsh_q <= LCM_IDLE;
			sub_do_o <= 1'b0;
			sub_oe_o <= 1'b0;
			trunk_oe_o <= '0;
		end else begin
			lk_dt_q <= {lk_dt_q[1:0], ds_tog_q};
			if (lk_dnew) begin
				lk_dhold_q <= ds_byte_q;
				lk_dslot_q <= ds_slot_q;
			end
			if (lk_last) begin
				lk_dsh_q <= (lk_dslot_q == lcm_slot_t'(lk_slot + 5'h01)) ? lk_dhold_q : LCM_IDLE;
			end else begin
				lk_dsh_q <= {lk_dsh_q[6:0], 1'b1};
			end
			sub_do_o <= 1'b0;
			sub_oe_o <= lk_lv2_q[5] & ~lk_dsh_q[7];
			trunk_oe_o <= {4{lk_lv2_q[4]}} & ~lk_lv2_q[3:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_fill_go;
		cmd_wr_i && !busy_q && mode_q == LCM_MODE_RESET && mem_cmd_i == LCM_CMD_CLR;
	endsequence
	sequence s_fill_run;
		busy_o [*8] ##[240:260] !busy_o;
	endsequence

	AST_RESET_MODE: assert property ($fell(rst_i) |-> mode_q == LCM_MODE_RESET)
		else $error("mode not reset mode after reset");
	AST_FILL_ALL: assert property (s_fill_go |=> s_fill_run)
		else $error("memory fill length wrong");
	AST_WRITE_CODE: assert property (wr_go && is_wr7 |=>
		code_mem[$past(mem_addr_i)] == $past(mem_cmd_i[3:0]) && data_mem[$past(mem_addr_i)] == $past(mem_data_i))
		else $error("data and code write lost");
	AST_DATA_ONLY: assert property (wr_go && !is_wr7 |=>
		code_mem[$past(mem_addr_i)] == $past(code_mem[mem_addr_i]))
		else $error("data-only write changed code");
	AST_READ_BACK: assert property (rd_go |=> mem_rdata_o == $past(host_rd))
		else $error("read data mismatch");
	AST_TRISTATE: assert property (tri_go |=> tri_q == $past(mem_data_i[3:0]))
		else $error("tristate memory not loaded");
	AST_STARTUP: assert property (start |-> ##2 (main_status_o & (LCM_ST_CIC | LCM_ST_SYNC)) == 8'h48)
		else $error("start-up status not flagged");
	AST_CIF_CLEAR: assert property (cif_clr && !push |=> cif_cnt == '0)
		else $error("change fifo not emptied");
	AST_CIC_LEVEL: assert property (cif_ne |=> main_status_o[6])
		else $error("change status missing with fifo entry");
	AST_RX_COUNT: assert property (rx_end_i && !rx_valid_i |=> rx_count_o == $past(rx_cnt_q) + 8'h01)
		else $error("byte count lacks status byte");
	AST_XPR: assert property (xmit_go |-> ##[2:200] hs_q[4])
		else $error("pool ready not reported");
endmodule

// >>> src/lcm_pkg.sv
package lcm_pkg;
	typedef logic [7:0] lcm_byte_t;
	typedef logic [3:0] lcm_code_t;
	typedef logic [4:0] lcm_slot_t;
	typedef enum logic {
		LCM_TX_IDLE = 1'b0,
		LCM_TX_SEND = 1'b1
	} lcm_tx_t;

	// operation modes
	localparam lcm_byte_t LCM_MODE_RESET = 8'h00;
	localparam lcm_byte_t LCM_MODE_INIT  = 8'h80;
	localparam lcm_byte_t LCM_MODE_NORM  = 8'hCE;
	localparam lcm_byte_t LCM_MODE_TRUNK = 8'hEE;
	// memory and controller commands
	localparam lcm_byte_t LCM_CMD_CLR     = 8'h70;
	localparam lcm_code_t LCM_CMD_WR_NIB  = 4'h7;
	localparam lcm_byte_t LCM_CMD_WR_DATA = 8'h48;
	localparam lcm_byte_t LCM_CMD_RD_DATA = 8'hC8;
	localparam lcm_byte_t LCM_CMD_TRI_ALL = 8'h68;
	localparam lcm_byte_t LCM_CMD_CIF_CLR = 8'h10;
	localparam lcm_byte_t LCM_CMD_XMIT    = 8'h0A;
	localparam lcm_byte_t LCM_CMD_RX_ACK  = 8'h80;
	// location codes
	localparam lcm_code_t LCM_CODE_UNASSIGNED = 4'h0;
	localparam lcm_code_t LCM_CODE_DS_EVEN    = 4'hA;
	localparam lcm_code_t LCM_CODE_DS_ODD     = 4'hB;
	localparam lcm_code_t LCM_CODE_US_EVEN    = 4'h8;
	localparam lcm_code_t LCM_CODE_US_ODD     = 4'h0;
	localparam logic      LCM_DIR_UP          = 1'b1;
	localparam logic      LCM_DIR_DOWN        = 1'b0;
	// command/indication field inside a control byte
	localparam int        LCM_CI_LSB   = 2;
	localparam int        LCM_CI_MSB   = 5;
	localparam int        LCM_ARB_BIT  = 4;
	localparam lcm_byte_t LCM_IDLE     = 8'hFF;
	localparam lcm_byte_t LCM_CIF_SPUR = 8'hFF;
	// status bits
	localparam lcm_byte_t LCM_ST_CIC  = 8'h40;
	localparam lcm_byte_t LCM_ST_SYNC = 8'h08;
	localparam lcm_byte_t LCM_ST_HDLC = 8'h02;
	localparam lcm_byte_t LCM_HS_RME  = 8'h80;
	localparam lcm_byte_t LCM_HS_XPR  = 8'h10;
	// framing
	localparam lcm_slot_t LCM_SLOT_LEAD = 5'h02;
	localparam logic [2:0] LCM_LAST_BIT = 3'h7;
	localparam lcm_byte_t LCM_CLR_LAST  = 8'hFF;
	localparam int        LCM_CIF_DEPTH = 8;
	localparam int        LCM_TX_DEPTH  = 32;

	// memory address of a slot on port 0
	function automatic lcm_byte_t lcm_slot_addr(input logic dir, input lcm_slot_t s);
		return {dir, s[4:1], 2'b00, s[0]};
	endfunction
endpackage
